// ---- hw/pcfrg_pkg.sv ----
package pcfrg_pkg;
   // Reset/lock hold, counted in base-clock cycles
   localparam int unsigned RELEASE_CYCLES = 1024;
   localparam logic [10:0] RELEASE_LAST = 11'h3ff;
   // Shortest accepted reset-request low pulse
   localparam int unsigned REQ_MIN_NS = 10;
   localparam int unsigned CLK_PERIOD_NS = 10;
   localparam int unsigned REQ_MIN_CYC =
      (REQ_MIN_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
   // Restart window after output stop is negated, in base cycles
   localparam int unsigned RESTART_CYCLES = 3;
   // Phase counter: bit0 double rate, bit1 base, bit2 half rate
   localparam int unsigned PHASE_W = 3;
   localparam int unsigned SYNC_STAGES = 2;
   typedef enum logic [1:0] {
      PCFRG_WAIT_LOCK,
      PCFRG_COUNT,
      PCFRG_RELEASED
   } pcfrg_state_t;
endpackage

// ---- hw/pcfrg_sync.sv ----
`timescale 1ns/1ps
// Two-flop synchroniser; the first stage feeds only the second
module pcfrg_sync (
   input wire logic clk_sys,
   input wire logic reset_n,
   input wire logic din,
   output logic dout
);
   logic meta_q;
   always_ff @(posedge clk_sys) begin
      if (!reset_n) begin
         meta_q <= 1'b0;
         dout <= 1'b0;
      end else begin
         meta_q <= din;
         dout <= meta_q;
      end
   end
endmodule

// ---- hw/pcfrg_top.sv ----
`timescale 1ns/1ps
// Functional notes
// - Inverted output is complement of free-running base output 2
// - Double-rate output toggles twice base rate
// - Half-rate output runs free; nothing inside uses it
// - Loop enable low gives bypass mode stepped by the reference
// - Reset/lock output only pulls low
// - Request high: low until lock plus 1024
// - Request low at power-up: 1024 after rise
// - Locked short request low forces 1024 cycles
// - Clocks keep running during reset hold
// - Release right after the 1024th cycle
// - Stop holds double-rate and two base outputs
// - Stopped outputs run within three cycles
module pcfrg_top (
   input wire logic clk_sys,
   input wire logic reset_n,
   input wire logic vco_clk,
   input wire logic ref_clk,
   input wire logic loop_enable,
   input wire logic lock_detect,
   input wire logic reset_request,
   input wire logic output_stop,
   output logic [2:0] base_clk_out,
   output logic inverted_clk_out,
   output logic double_rate_clk_out,
   output logic half_rate_clk_out,
   output logic reset_lock_o,
   output logic reset_lock_oe
);
   logic vco_s, ref_s, lock_s, req_s, stop_s, len_s;
   logic vco_prev_q, ref_prev_q;
   logic [pcfrg_pkg::PHASE_W-1:0] phase_q;
   logic [pcfrg_pkg::PHASE_W-1:0] phase_d;
   logic [10:0] count_q;
   logic pend_q;
   logic base_q, dbl_q, half_q;
   logic [2:0] base_out_q;
   pcfrg_pkg::pcfrg_state_t state_q;

   wire [5:0] pin_raw = {loop_enable, output_stop, reset_request, lock_detect, ref_clk, vco_clk};
   logic [5:0] pin_s;
   // Every pin is asynchronous, so each one passes two flops before use
   genvar s;
   generate
      for (s = 0; s < 6; s++) begin : g_sync
         pcfrg_sync u_sync (
            .clk_sys(clk_sys),
            .reset_n(reset_n),
            .din(pin_raw[s]),
            .dout(pin_s[s])
         );
      end
   endgenerate

   assign vco_s = pin_s[0];
   assign ref_s = pin_s[1];
   assign lock_s = pin_s[2];
   assign req_s = pin_s[3];
   assign stop_s = pin_s[4];
   assign len_s = pin_s[5];

   // Oscillator edges step the divider; bypass steps it from the reference
   wire vco_rise = vco_s & ~vco_prev_q;
   wire ref_edge = ref_s ^ ref_prev_q;
   wire step = len_s ? vco_rise : ref_edge;
   assign phase_d = phase_q + 3'h1;
   // Base rising edge: phase bit1 goes 0 to 1
   wire base_rise = step & (phase_d[1:0] == 2'h2);
   wire base_q_d = phase_d[1];
   wire locked = len_s ? lock_s : 1'b1;
   // Stopped outputs wait for a base rising edge so no runt pulse leaves
   logic gate_q;
   always_ff @(posedge clk_sys) begin
      if (!reset_n) begin
         gate_q <= 1'b0;
      end else if (stop_s) begin
         // Set wins over clear when a stop lands on a base edge
         gate_q <= 1'b1;
      end else if (base_rise) begin
         gate_q <= 1'b0;
      end
   end
   wire stop_hold = stop_s | gate_q;

   // Previous synchronised levels for edge detection
   always_ff @(posedge clk_sys) begin
      if (!reset_n) begin
         vco_prev_q <= 1'b0;
         ref_prev_q <= 1'b0;
      end else begin
         vco_prev_q <= vco_s;
         ref_prev_q <= ref_s;
      end
   end

   // Divider never stops, even while stopped outputs are held
   always_ff @(posedge clk_sys) begin
      if (!reset_n) begin
         phase_q <= 3'h0;
      end else if (step) begin
         phase_q <= phase_d;
      end
   end

   always_ff @(posedge clk_sys) begin
      if (!reset_n) begin
         base_q <= 1'b0;
         dbl_q <= 1'b0;
         half_q <= 1'b0;
      end else if (step) begin
         dbl_q <= phase_d[0] ? 1'b0 : 1'b1;
         base_q <= base_q_d;
         half_q <= phase_d[2];
      end
   end

   // Stop gating; base output 2 never stops, including during reset hold
   genvar g;
   generate
      for (g = 0; g < 3; g++) begin : g_base
         if (g < 2) begin : g_gated
            always_ff @(posedge clk_sys) begin
               if (!reset_n) begin
                  base_out_q[g] <= 1'b0;
               end else begin
                  base_out_q[g] <= stop_hold ? 1'b0 : base_q;
               end
            end
         end else begin : g_free
            always_ff @(posedge clk_sys) begin
               if (!reset_n) begin
                  base_out_q[g] <= 1'b0;
               end else begin
                  base_out_q[g] <= base_q;
               end
            end
         end
      end
   endgenerate

   // Every output leaves through one register stage so all edges line up
   logic dbl_out_q, inv_out_q, half_out_q;
   always_ff @(posedge clk_sys) begin
      if (!reset_n) begin
         dbl_out_q <= 1'b0;
         inv_out_q <= 1'b1;
         half_out_q <= 1'b0;
      end else begin
         dbl_out_q <= stop_hold ? 1'b0 : dbl_q;
         inv_out_q <= ~base_q;
         half_out_q <= half_q;
      end
   end

   assign base_clk_out = base_out_q;
   assign inverted_clk_out = inv_out_q;
   assign double_rate_clk_out = dbl_out_q;
   assign half_rate_clk_out = half_out_q;

   // Request low pulse of at least one sample re-arms the hold
   wire req_low = ~req_s;
   wire count_last = count_q == pcfrg_pkg::RELEASE_LAST;
   pcfrg_pkg::pcfrg_state_t state_d;
   logic [10:0] count_d;
   always_comb begin
      state_d = state_q;
      count_d = count_q;
      case (state_q)
         pcfrg_pkg::PCFRG_WAIT_LOCK: begin
            count_d = 11'h000;
            if (locked && !req_low) begin
               state_d = pcfrg_pkg::PCFRG_COUNT;
            end
         end
         pcfrg_pkg::PCFRG_COUNT: begin
            // Loss of lock restarts the wait; a partial count never survives it
            if (!locked) begin
               state_d = pcfrg_pkg::PCFRG_WAIT_LOCK;
               count_d = 11'h000;
            end else if (req_low) begin
               count_d = 11'h000;
            end else if (base_rise) begin
               count_d = count_q + 11'h001;
               if (count_last) begin
                  state_d = pcfrg_pkg::PCFRG_RELEASED;
               end
            end
         end
         pcfrg_pkg::PCFRG_RELEASED: begin
            if (req_low) begin
               state_d = pcfrg_pkg::PCFRG_COUNT;
               count_d = 11'h000;
            end else if (!locked) begin
               state_d = pcfrg_pkg::PCFRG_WAIT_LOCK;
            end
         end
         default: begin
            state_d = pcfrg_pkg::PCFRG_WAIT_LOCK;
            count_d = 11'h000;
         end
      endcase
   end

   always_ff @(posedge clk_sys) begin
      if (!reset_n) begin
         state_q <= pcfrg_pkg::PCFRG_WAIT_LOCK;
         count_q <= 11'h000;
         pend_q <= 1'b0;
      end else begin
         state_q <= state_d;
         count_q <= count_d;
         pend_q <= state_q != pcfrg_pkg::PCFRG_RELEASED;
      end
   end

   // Open drain: value always low, enable pulls
   assign reset_lock_o = 1'b0;
   assign reset_lock_oe = pend_q;
endmodule

// ---- tb/pcfrg_far.sv ----
`timescale 1ns/1ps
// Clocks run free; lock rises once, well after reset
module pcfrg_far (
   output logic vco_clk,
   output logic ref_clk,
   output logic lock_detect
);
   initial {vco_clk, ref_clk, lock_detect} = 3'h0;
   initial #3003 lock_detect = 1'b1;
   // Oscillator at six system cycles keeps both holds inside the run budget
   always #30 vco_clk = ~vco_clk;
   always #80 ref_clk = ~ref_clk;
endmodule

// ---- tb/pcfrg_props.sv ----
`timescale 1ns/1ps
module pcfrg_props (
   input wire logic clk_sys,
   input wire logic reset_n,
   input wire logic reset_request,
   input wire logic output_stop,
   input wire logic [2:0] base_clk_out,
   input wire logic inverted_clk_out,
   input wire logic reset_lock_o,
   input wire logic reset_lock_oe
);
   logic [10:0] edge_q;
   logic base_q;
   wire out_rise = base_clk_out[2] && !base_q;
   always_ff @(posedge clk_sys) begin
      base_q <= base_clk_out[2];
      if (!reset_n || !reset_lock_oe || !reset_request) edge_q <= '0;
      else if (base_clk_out[2] && !base_q) edge_q <= edge_q + 11'h1;
   end
   default clocking cb @(posedge clk_sys); endclocking
   default disable iff (!reset_n);
   chk_inv_out: assert property (inverted_clk_out != base_clk_out[2]) else $error("inv");
   chk_pin_low: assert property (reset_lock_o == 1'b0) else $error("pin driven high");
   chk_pair_eq: assert property (base_clk_out[0] == base_clk_out[1]) else $error("pair");
   chk_hold_max: assert property (edge_q <= 11'h401) else $error("hold too long");
   chk_stop_low: assert property (output_stop [*6] |-> !base_clk_out[0])
      else $error("stopped output moving");
   chk_hold_cnt: assert property ($fell(reset_lock_oe) |-> (edge_q + {10'h000, out_rise}) >= 11'h400)
      else $error("hold too short");
   chk_req_pulls: assert property (!reset_request [*5] |=> reset_lock_oe)
      else $error("request not seen");
   chk_restart: assert property ($fell(output_stop) |-> ##[1:100] &base_clk_out)
      else $error("no restart");
   cover property ($fell(reset_lock_oe));
   cover property (output_stop [*6]);
   cover property (!reset_request [*5]);
endmodule

// ---- tb/pcfrg_top_tb.sv ----
`timescale 1ns/1ps
module pcfrg_top_tb;
   logic clk_sys = 0, reset_n = 0, reset_request = 0, output_stop = 0, loop_enable = 1;
   logic vco_clk, ref_clk, lock_detect, inverted_clk_out, double_rate_clk_out, reset_lock_oe;
   logic half_rate_clk_out;
   logic [2:0] base_clk_out;
   int error_cnt = 0, tests_run = 0, n, nb, nd, nh, nq, nr;
   always #5 clk_sys = ~clk_sys;
   always @(posedge base_clk_out[2]) nb++;
   always @(posedge base_clk_out[2]) nh++;
   always @(posedge double_rate_clk_out) nd++;
   always @(posedge half_rate_clk_out) nq++;
   always @(posedge ref_clk) nr++;
   pcfrg_far far (
      .vco_clk(vco_clk),
      .ref_clk(ref_clk),
      .lock_detect(lock_detect)
   );
   pcfrg_top dut (
      .clk_sys(clk_sys),
      .reset_n(reset_n),
      .vco_clk(vco_clk),
      .ref_clk(ref_clk),
      .loop_enable(loop_enable),
      .lock_detect(lock_detect),
      .reset_request(reset_request),
      .output_stop(output_stop),
      .base_clk_out(base_clk_out),
      .inverted_clk_out(inverted_clk_out),
      .double_rate_clk_out(double_rate_clk_out),
      .half_rate_clk_out(half_rate_clk_out),
      .reset_lock_o(),
      .reset_lock_oe(reset_lock_oe)
   );
   task automatic check(string what, logic [15:0] exp, logic [15:0] got);
      tests_run++;
      if (got !== exp) error_cnt++;
      if (got !== exp) $display("Error %s expected %0d seen %0d", what, exp, got);
   endtask
   task automatic give_verdict();
      if (error_cnt == 0 && tests_run > 0) $display("DONE - PASS");
      else $display("DONE - FAIL");
      $finish;
   endtask
   task automatic hold_ends();
      for (n = 0; n < 40000 && reset_lock_oe !== 1'b0; n++) @(negedge clk_sys);
      error_cnt += (n == 40000);
      // An edge may fall in the synchroniser gap, so one extra is allowed
      if (n == 40000) give_verdict();
      else check("hold edges", 1, nh inside {[1024:1025]});
   endtask
   initial begin
      void'($urandom(32'h4c44));
      repeat (4) @(negedge clk_sys);
      reset_n = 1;
      repeat (500) @(negedge clk_sys);
      nh = 0;
      reset_request = 1;
      hold_ends();
      reset_request = 0;
      repeat ($urandom_range(9, 6)) @(negedge clk_sys);
      nh = 0;
      reset_request = 1;
      output_stop = 1;
      nb = 0;
      repeat ($urandom_range(900, 300)) @(negedge clk_sys);
      check("stopped", 0, {base_clk_out[1:0], double_rate_clk_out});
      check("free base", 1, nb > 4);
      output_stop = 0;
      nb = 0;
      nd = 0;
      nq = 0;
      repeat (640) @(negedge clk_sys);
      check("double", 1, nd inside {[2 * nb - 3:2 * nb + 1]});
      check("half", 1, 2 * nq inside {[nb - 2:nb + 2]});
      hold_ends();
      loop_enable = 0;
      repeat (20) @(negedge clk_sys);
      nb = 0;
      nr = 0;
      repeat (640) @(negedge clk_sys);
      check("bypass base", 1, 2 * nb inside {[nr - 2:nr + 2]});
      check("bypass oe", 0, reset_lock_oe);
      give_verdict();
   end
endmodule
bind pcfrg_top pcfrg_props chk (
   .clk_sys(clk_sys),
   .reset_n(reset_n),
   .reset_request(reset_request),
   .output_stop(output_stop),
   .base_clk_out(base_clk_out),
   .inverted_clk_out(inverted_clk_out),
   .reset_lock_o(reset_lock_o),
   .reset_lock_oe(reset_lock_oe)
);
